// ### bie_alu.sv
`include "bie_cfg.svh"
`default_nettype none
module bie_alu import bie_pkg::*; (
  // Operation select
  input  wire logic [2:0]   opSel,
  // Operands
  input  wire logic [7:0]   accValue,
  input  wire logic [7:0]   fileValue,
  input  wire logic [7:0]   immValue,
  // Result
  output var bie_alu_out_t  result
);

  // Combinational datapath for the one-cycle operations
  always_comb begin
    result = '0;
    unique case (opSel)
      `BIE_CODE_ORI: result.value = accValue | immValue;
      `BIE_CODE_INC: result.value = fileValue + 8'h01;
      `BIE_CODE_ORR: result.value = accValue | fileValue;
      `BIE_CODE_SHL: begin
        result.value      = {fileValue[6:0], 1'b0};
        result.carryOut   = fileValue[7];
        result.carryValid = 1'b1;
      end
      `BIE_CODE_SHR: begin
        result.value      = {1'b0, fileValue[7:1]};
        result.carryOut   = fileValue[0];
        result.carryValid = 1'b1;
      end
      default: result.value = 8'h00;
    endcase
    result.zero = (result.value == 8'h00);
  end

endmodule // bie_alu
`default_nettype wire

// ### bie_cfg.svh
`ifndef BIE_CFG_SVH
`define BIE_CFG_SVH

// Register byte offsets on the APB window
`define BIE_OFF_INSTR     8'h00
`define BIE_OFF_ACC       8'h04
`define BIE_OFF_LATCH     8'h08
`define BIE_OFF_PC        8'h0C
`define BIE_OFF_STATUS    8'h10
`define BIE_OFF_FADDR     8'h14
`define BIE_OFF_FDATA     8'h18

// Instruction word fields
`define BIE_INSTR_OPD_LSB 0
`define BIE_INSTR_OPD_MSB 10
`define BIE_INSTR_DEST    11
`define BIE_INSTR_OP_LSB  12
`define BIE_INSTR_OP_MSB  14

// Opcode field values
`define BIE_CODE_JUMP     3'h1
`define BIE_CODE_ORI      3'h2
`define BIE_CODE_INC      3'h3
`define BIE_CODE_ORR      3'h4
`define BIE_CODE_SHL      3'h5
`define BIE_CODE_SHR      3'h6

// Status fields
`define BIE_STAT_CARRY    0
`define BIE_STAT_ZERO     1
`define BIE_STAT_BUSY     2

// Widths and jump fields
`define BIE_PC_W          15
`define BIE_LATCH_W       7
`define BIE_LATCH_HI      6
`define BIE_LATCH_LO      3
`define BIE_FADDR_W       7

// Reset values
`define BIE_RST_ACC       8'h00
`define BIE_RST_LATCH     7'h00
`define BIE_RST_PC        15'h0000
`define BIE_RST_WORD      32'h0000_0000

`endif

// ### bie_exec.sv
// Notes on behaviour
// - Jump loads 11-bit immediate into counter 10:0
// - Jump fills counter 14:11 from latch 6:3
// - Jump takes two cycles, flags untouched
// - OR immediate into accumulator, zero flag only
// - Increment register modulo 256, zero flag only
// - Target bit 0 accumulator, 1 register; OR immediate always writes the accumulator
// - OR accumulator with register, zero flag only
// - Left shift: bit 7 to carry, zero in
// - Right shift: bit 0 to carry, zero in
//
// Chosen here: the register offsets and the APB register port.
`include "bie_cfg.svh"
`default_nettype none
module bie_exec import bie_pkg::*; #(
  parameter int FILE_DEPTH = 128
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          rst,
  // APB slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  // Core state
  output logic [14:0]        programCounter,
  output logic [7:0]         accumulator,
  output logic               carryFlag,
  output logic               zeroFlag,
  output logic               busy
);

  // Sequencer and architectural state
  bie_state_t             state;
  bie_state_t             next_state;
  bie_instr_t             curInstr;
  bie_instr_t             next_curInstr;
  logic [2:0]             curCode;
  logic [2:0]             next_curCode;
  logic [6:0]             upperTargetLatch;
  logic [6:0]             next_upperTargetLatch;
  logic [6:0]             fileAddr;
  logic [6:0]             next_fileAddr;
  logic [14:0]            next_programCounter;
  logic [7:0]             next_accumulator;
  logic                   next_carryFlag;
  logic                   next_zeroFlag;
  logic [31:0]            next_prdata;

  // Register file and its write port
  logic [7:0]             regFile [FILE_DEPTH];
  logic                   fileWe;
  logic [6:0]             fileWAddr;
  logic [7:0]             fileWData;
  bie_alu_out_t           aluOut;

  // Bus decode helpers
  logic                   setupPhase;
  logic                   accessWrite;
  logic [2:0]             reqCode;
  logic                   issueBad;

  // True for an opcode field that names an operation
  function automatic logic codeLegal(input logic [2:0] code);
    return (code >= `BIE_CODE_JUMP) && (code <= `BIE_CODE_SHR);
  endfunction

  // True for a mapped register offset
  function automatic logic offMapped(input logic [7:0] off);
    return (off == `BIE_OFF_INSTR) || (off == `BIE_OFF_ACC) ||
           (off == `BIE_OFF_LATCH) || (off == `BIE_OFF_PC) ||
           (off == `BIE_OFF_STATUS) || (off == `BIE_OFF_FADDR) ||
           (off == `BIE_OFF_FDATA);
  endfunction

  // Datapath for one-cycle operations
  bie_alu bie_alu_inst (
    .opSel     (curCode),
    .accValue  (accumulator),
    .fileValue (regFile[curInstr.operand[6:0]]),
    .immValue  (curInstr.operand[7:0]),
    .result    (aluOut)
  );

  // Zero wait states: every access phase completes at once
  assign pready      = 1'b1;

  // Bus phase decode and error answer
  assign setupPhase  = psel && !penable;
  assign accessWrite = psel && penable && pwrite;
  assign reqCode     = pwdata[`BIE_INSTR_OP_MSB:`BIE_INSTR_OP_LSB];
  // Refuse an issue while busy or with an opcode outside the set
  assign issueBad    = (paddr == `BIE_OFF_INSTR) && pwrite &&
                       (busy || !codeLegal(reqCode));
  assign pslverr     = psel && penable && (!offMapped(paddr) || issueBad);
  assign busy        = (state != ST_IDLE);

  // Next values of sequencer, registers and file write port
  always_comb begin
    // Defaults hold every register and keep the file port idle
    next_state            = state;
    next_curInstr         = curInstr;
    next_curCode          = curCode;
    next_upperTargetLatch = upperTargetLatch;
    next_fileAddr         = fileAddr;
    next_programCounter   = programCounter;
    next_accumulator      = accumulator;
    next_carryFlag        = carryFlag;
    next_zeroFlag         = zeroFlag;
    next_prdata           = prdata;
    fileWe                = 1'b0;
    fileWAddr             = fileAddr;
    fileWData             = pwdata[7:0];
    // Software writes
    // A refused access leaves every register as it was
    if (accessWrite && !pslverr) begin
      unique case (paddr)
        `BIE_OFF_INSTR: begin
          next_curInstr.operand =
            pwdata[`BIE_INSTR_OPD_MSB:`BIE_INSTR_OPD_LSB];
          next_curInstr.dest = pwdata[`BIE_INSTR_DEST];
          next_curCode       = reqCode;
          next_state         = ST_EXEC;
        end
        `BIE_OFF_ACC:    next_accumulator = pwdata[7:0];
        `BIE_OFF_LATCH:  next_upperTargetLatch = pwdata[6:0];
        `BIE_OFF_STATUS: begin
          next_carryFlag = pwdata[`BIE_STAT_CARRY];
          next_zeroFlag  = pwdata[`BIE_STAT_ZERO];
        end
        `BIE_OFF_FADDR:  next_fileAddr = pwdata[6:0];
        `BIE_OFF_FDATA:  fileWe = 1'b1;
        default: ;
      endcase
    end
    // Execution; hardware updates win over a same-cycle software write
    unique case (state)
      ST_IDLE: ;
      ST_EXEC: begin
        // Jump: counter from latch and immediate, flags untouched
        if (curCode == `BIE_CODE_JUMP) begin
          next_programCounter = {
            upperTargetLatch[`BIE_LATCH_HI:`BIE_LATCH_LO],
            curInstr.operand};
          next_state = ST_FLUSH;
        end else begin
          // One-cycle operation: counter steps, result to its target
          next_programCounter = programCounter + 15'h0001;
          if (curCode == `BIE_CODE_ORI || !curInstr.dest) begin
            next_accumulator = aluOut.value;
          end else begin
            fileWe    = 1'b1;
            fileWAddr = curInstr.operand[6:0];
            fileWData = aluOut.value;
          end
          // Zero flag always; carry only from the two shifts
          next_zeroFlag = aluOut.zero;
          if (aluOut.carryValid) begin
            next_carryFlag = aluOut.carryOut;
          end
          next_state = ST_IDLE;
        end
      end
      // Second jump cycle: the fetched word is discarded
      ST_FLUSH: next_state = ST_IDLE;
    endcase
    // Read data captured in the setup phase
    // Unmapped offsets read as zero
    if (setupPhase && !pwrite) begin
      unique case (paddr)
        `BIE_OFF_INSTR:  next_prdata = {17'h0_0000, curCode,
                                        curInstr.dest, curInstr.operand};
        `BIE_OFF_ACC:    next_prdata = {24'h00_0000, accumulator};
        `BIE_OFF_LATCH:  next_prdata = {25'h000_0000, upperTargetLatch};
        `BIE_OFF_PC:     next_prdata = {17'h0_0000, programCounter};
        `BIE_OFF_STATUS: next_prdata = {29'h000_0000, busy, zeroFlag,
                                        carryFlag};
        `BIE_OFF_FADDR:  next_prdata = {25'h000_0000, fileAddr};
        `BIE_OFF_FDATA:  next_prdata = {24'h00_0000, regFile[fileAddr]};
        default:         next_prdata = `BIE_RST_WORD;
      endcase
    end
  end

  // Register the control state
  always_ff @(posedge clk) begin
    if (rst) begin
      state            <= ST_IDLE;
      curInstr         <= '0;
      curCode          <= 3'h0;
      upperTargetLatch <= `BIE_RST_LATCH;
      fileAddr         <= 7'h00;
      programCounter   <= `BIE_RST_PC;
      accumulator      <= `BIE_RST_ACC;
      carryFlag        <= 1'b0;
      zeroFlag         <= 1'b0;
      prdata           <= `BIE_RST_WORD;
    end else begin
      state            <= next_state;
      curInstr         <= next_curInstr;
      curCode          <= next_curCode;
      upperTargetLatch <= next_upperTargetLatch;
      fileAddr         <= next_fileAddr;
      programCounter   <= next_programCounter;
      accumulator      <= next_accumulator;
      carryFlag        <= next_carryFlag;
      zeroFlag         <= next_zeroFlag;
      prdata           <= next_prdata;
    end
  end

  // Register file storage, no reset
  always_ff @(posedge clk) begin
    if (fileWe) begin
      regFile[fileWAddr] <= fileWData;
    end
  end

endmodule // bie_exec
`default_nettype wire

// ### bie_exec_monitor.sv
`default_nettype none
module bie_exec_monitor (
  // Clock and APB
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pslverr,
  // Core state
  input wire logic [14:0] programCounter,
  input wire logic [7:0]  accumulator,
  input wire logic        carryFlag,
  input wire logic        zeroFlag,
  input wire logic        busy
);
  // Issue decode and shadow of the upper target latch
  logic [6:0] lat;
  logic [6:0] next_lat;
  wire        isIssue = psel & penable & pwrite & paddr == 8'h00 & !pslverr;
  wire        latWrite = psel & penable & pwrite & paddr == 8'h08 & !pslverr;
  wire  [2:0] op = pwdata[14:12];
  wire        toAcc = op == 3'h2 || !pwdata[11];
  wire        isJump = isIssue && op == 3'h1;
  wire        isOne = isIssue && op >= 3'h2 && op <= 3'h6;
  // Shadow copy of the upper target latch
  always_comb begin
    next_lat = lat;
    if (latWrite) begin
      next_lat = pwdata[6:0];
    end
  end
  // Register the shadow copy
  always_ff @(posedge clk) begin
    lat <= rst ? 7'h00 : next_lat;
  end
  // One clock domain, idle under reset
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Busy for one cycle, or two for the jump
  sequence oneExec;
    busy ##1 !busy;
  endsequence
  sequence jumpExec;
    busy [*2] ##1 !busy;
  endsequence
  AST_JUMP_TIME: assert property (isJump |-> ##1 jumpExec)
    else $error("jump busy length wrong");
  AST_JUMP_FLAGS: assert property (isJump |-> ##3
    carryFlag == $past(carryFlag, 3) && zeroFlag == $past(zeroFlag, 3))
    else $error("jump changed flags");
  AST_JUMP_LOW: assert property (isJump |-> ##2
    programCounter[10:0] == $past(pwdata[10:0], 2))
    else $error("jump low counter bits wrong");
  AST_JUMP_HIGH: assert property (isJump |-> ##2
    programCounter[14:11] == $past(lat[6:3], 2))
    else $error("jump high counter bits wrong");
  AST_SINGLE: assert property (isOne |-> ##1 oneExec)
    else $error("op not one cycle");
  AST_ORI: assert property (isIssue && op == 3'h2 |-> ##2
    accumulator == ($past(accumulator, 2) | $past(pwdata[7:0], 2))
    && carryFlag == $past(carryFlag, 2)) else $error("or immediate wrong");
  AST_ZERO: assert property (isOne && toAcc |-> ##2
    zeroFlag == (accumulator == 8'h00)) else $error("zero flag wrong");
  AST_KEEP_ACC: assert property (isOne && op != 3'h2 && pwdata[11]
    |-> ##2 accumulator == $past(accumulator, 2))
    else $error("register target touched accumulator");
  AST_SHL_IN: assert property (isIssue && op == 3'h5 && toAcc
    |-> ##2 !accumulator[0]) else $error("left shift bit 0 not zero");
  AST_SHR_IN: assert property (isIssue && op == 3'h6 && toAcc
    |-> ##2 !accumulator[7]) else $error("right shift bit 7 not zero");
endmodule // bie_exec_monitor
bind bie_exec bie_exec_monitor bie_exec_monitor_inst (
  .clk            (clk),
  .rst            (rst),
  .psel           (psel),
  .penable        (penable),
  .pwrite         (pwrite),
  .paddr          (paddr),
  .pwdata         (pwdata),
  .pslverr        (pslverr),
  .programCounter (programCounter),
  .accumulator    (accumulator),
  .carryFlag      (carryFlag),
  .zeroFlag       (zeroFlag),
  .busy           (busy)
);
`default_nettype wire

// ### bie_pkg.sv
`default_nettype none
package bie_pkg;

  // Decoded operation
  typedef enum {
    OP_NONE, OP_JUMP, OP_ORI, OP_INC, OP_ORR, OP_SHL, OP_SHR
  } bie_op_t;

  // Sequencer states
  typedef enum {ST_IDLE, ST_EXEC, ST_FLUSH} bie_state_t;

  // Issued instruction
  typedef struct packed {
    logic        dest;
    logic [10:0] operand;
  } bie_instr_t;

  // Result of the datapath
  typedef struct packed {
    logic [7:0] value;
    logic       carryOut;
    logic       carryValid;
    logic       zero;
  } bie_alu_out_t;

endpackage
`default_nettype wire

// ### tb_bie_exec.sv
`default_nettype none
module tb_bie_exec;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, e;
  logic        carryFlag, zeroFlag, busy;
  logic [7:0]  paddr, accumulator;
  logic [31:0] pwdata, prdata, r;
  logic [14:0] programCounter;
  int          n_errors = 0;
  int          tests_run = 0;
  bie_exec bie_exec_inst (
    .clk            (clk),
    .rst            (rst),
    .psel           (psel),
    .penable        (penable),
    .pwrite         (pwrite),
    .paddr          (paddr),
    .pwdata         (pwdata),
    .prdata         (prdata),
    .pready         (pready),
    .pslverr        (pslverr),
    .programCounter (programCounter),
    .accumulator    (accumulator),
    .carryFlag      (carryFlag),
    .zeroFlag       (zeroFlag),
    .busy           (busy)
  );
  // Clock and watchdog
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    #20000;
    n_errors++;
    finish_test();
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One APB transfer, held until pready
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Issue an instruction and wait for busy to drop
  task automatic op(input logic [2:0] c, input logic d, input logic [10:0] k);
    xfer(1'b1, 8'h00, {17'h0_0000, c, d, k});
    @(posedge clk);
    for (int i = 0; i < 8 && busy !== 1'b0; i++) @(posedge clk);
    check({31'h0000_0000, busy}, 32'h0000_0000);
  endtask
  task automatic fset(input logic [6:0] a, input logic [7:0] v);
    xfer(1'b1, 8'h14, {25'h000_0000, a});
    xfer(1'b1, 8'h18, {24'h00_0000, v});
  endtask
  task automatic fread(input logic [6:0] a);
    xfer(1'b1, 8'h14, {25'h000_0000, a});
    xfer(1'b0, 8'h18, 32'h0000_0000);
  endtask
  task automatic core(input logic [7:0] a, input logic [1:0] f);
    check({24'h00_0000, accumulator}, {24'h00_0000, a});
    check({30'h0000_0000, carryFlag, zeroFlag}, {30'h0000_0000, f});
  endtask
  task automatic testJump();
    xfer(1'b1, 8'h08, 32'h0000_005A);
    xfer(1'b1, 8'h10, 32'h0000_0001);
    op(3'h1, 1'b0, 11'h7FF);
    check({17'h0_0000, programCounter}, 32'h0000_5FFF);
    core(8'h00, 2'h2);
    $display("jump test done");
  endtask
  task automatic testOri();
    op(3'h2, 1'b1, 11'h000);
    core(8'h00, 2'h3);
    op(3'h2, 1'b0, 11'h0A5);
    core(8'hA5, 2'h2);
    $display("or immediate test done");
  endtask
  task automatic testInc();
    fset(7'h7F, 8'hFF);
    op(3'h3, 1'b1, 11'h07F);
    core(8'hA5, 2'h3);
    fread(7'h7F);
    check(r, 32'h0000_0000);
    op(3'h3, 1'b0, 11'h07F);
    core(8'h01, 2'h2);
    $display("increment test done");
  endtask
  task automatic testOrr();
    fset(7'h05, 8'hF0);
    op(3'h4, 1'b0, 11'h005);
    core(8'hF1, 2'h2);
    op(3'h4, 1'b1, 11'h005);
    fread(7'h05);
    check(r, 32'h0000_00F1);
    $display("or register test done");
  endtask
  task automatic testShift();
    fset(7'h09, 8'h81);
    op(3'h5, 1'b0, 11'h009);
    core(8'h02, 2'h2);
    op(3'h6, 1'b1, 11'h009);
    core(8'h02, 2'h2);
    fread(7'h09);
    check(r, 32'h0000_0040);
    fset(7'h09, 8'h01);
    op(3'h6, 1'b0, 11'h009);
    core(8'h00, 2'h3);
    // Shifts whose outgoing bit is zero must clear the carry
    fset(7'h09, 8'h7E);
    op(3'h5, 1'b1, 11'h009);
    core(8'h00, 2'h0);
    fread(7'h09);
    check(r, 32'h0000_00FC);
    op(3'h6, 1'b0, 11'h009);
    core(8'h7E, 2'h0);
    $display("shift test done");
  endtask
  task automatic testRefuse();
    xfer(1'b1, 8'h00, 32'h0000_7000);
    check({31'h0000_0000, e}, 32'h0000_0001);
    @(posedge clk);
    check({31'h0000_0000, busy}, 32'h0000_0000);
    xfer(1'b1, 8'h00, 32'h0000_0000);
    check({31'h0000_0000, e}, 32'h0000_0001);
    xfer(1'b0, 8'h1C, 32'h0000_0000);
    check({31'h0000_0000, e}, 32'h0000_0001);
    check(r, 32'h0000_0000);
    $display("refusal test done");
  endtask
  task automatic finish_test();
    $display("checks=%0d mismatches=%0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Reset, then the scenarios in turn
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    xfer(1'b0, 8'h0C, 32'h0000_0000);
    check(r, 32'h0000_0000);
    testJump();
    testOri();
    testInc();
    testOrr();
    testShift();
    testRefuse();
    finish_test();
  end
endmodule // tb_bie_exec
`default_nettype wire
